// ---- sim/flow_out_chk.sv ----
/*
  Port checker for the flowmeter output stage, bound to its top module.
  Assumes one clock, ref_clk, and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module flow_out_chk
  import flow_out_pkg::*;
#(
  parameter int unsigned CTL_MIN_CYC = 20,
  parameter int unsigned CTL_MAX_CYC = 160
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flowOverflow,
  input wire logic menuActive,
  input wire logic [15:0] anaLinUa,
  input wire logic devFault,
  input wire logic ctlPinIn,
  input wire logic out1Out,
  input wire logic out1Oe,
  input wire logic freqOut,
  input wire logic [15:0] anaOutUa,
  input wire logic minMaxRst,
  input wire logic partVolRst
);
  logic [15:0] pinRunQ; // high run of the pin
  logic [15:0] pinLastQ; // last finished high run of the pin
  logic [15:0] hiRunQ; // high run of the pulse output
  logic [15:0] loRunQ; // low run of the pulse output
  logic [15:0] hiLastQ; // width of the last finished pulse
  logic anyRst; // either reset pulse
  assign anyRst = minMaxRst | partVolRst;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // run counters; low runs saturate so long idle never wraps
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinRunQ <= 16'h0;
      pinLastQ <= 16'h0;
      hiRunQ <= 16'h0;
      loRunQ <= 16'h0;
      hiLastQ <= 16'h0;
    end else begin
      if (ctlPinIn) begin
        pinRunQ <= (pinRunQ == 16'hffff) ? pinRunQ : pinRunQ + 16'h1;
      end else begin
        pinRunQ <= 16'h0;
        pinLastQ <= (pinRunQ != 16'h0) ? pinRunQ : pinLastQ;
      end
      // an overflow hold is no pulse, so it is not measured
      if (out1Out) begin
        hiRunQ <= flowOverflow ? 16'h0 : hiRunQ + 16'h1;
        loRunQ <= 16'h0;
      end else begin
        hiRunQ <= 16'h0;
        loRunQ <= (loRunQ == 16'hffff) ? loRunQ : loRunQ + 16'h1;
        hiLastQ <= (hiRunQ != 16'h0) ? hiRunQ : hiLastQ;
      end
    end
  end

  AST_RST_ONECYC: assert property (anyRst |=> !anyRst)
    else $error("reset pulse longer than one clock");
  AST_RST_CTLMODE: assert property (
    anyRst |-> !out1Oe && !(minMaxRst && partVolRst))
    else $error("reset pulse outside control-input mode");
  AST_CTL_WINDOW: assert property (
    anyRst |-> pinLastQ > CTL_MIN_CYC - 2 && pinLastQ < CTL_MAX_CYC + 2)
    else $error("reset pulse after out-of-window command");
  AST_OVF_HIGH: assert property (
    flowOverflow [*3] ##0 out1Oe |-> out1Out)
    else $error("pulse output not held high in overflow");
  AST_MENU_HOLD: assert property (
    (menuActive && !flowOverflow && !out1Out) [*3] |=> !out1Out)
    else $error("pulse started in menu mode");
  AST_PULSE_GAP: assert property (
    $rose(out1Out) && !flowOverflow |-> loRunQ >= hiLastQ)
    else $error("low gap shorter than pulse width");
  AST_ANA_LIN: assert property (
    $past(rst_n) && !$past(devFault) && $past(anaLinUa) >= UA_LIN_LO &&
    $past(anaLinUa) <= UA_LIN_HI |-> anaOutUa == $past(anaLinUa))
    else $error("linear analogue code altered");
  AST_ANA_FAULT: assert property (
    $past(rst_n) && $past(devFault) |->
    anaOutUa == UA_FAULT || anaOutUa == $past(anaLinUa))
    else $error("fault code wrong");
  AST_ANA_OVER: assert property (
    $past(rst_n) && !$past(devFault) && $past(anaLinUa) > UA_LIN_HI |->
    anaOutUa == UA_OVER || anaOutUa == $past(anaLinUa))
    else $error("over-range code wrong");

  // main scenarios reached
  cover property (minMaxRst);
  cover property (partVolRst);
  cover property ($rose(out1Out) && !flowOverflow);
  cover property ($rose(freqOut));
endmodule // flow_out_chk

bind flow_pulse_freq_output flow_out_chk #(
  .CTL_MIN_CYC(CTL_MIN_CYC),
  .CTL_MAX_CYC(CTL_MAX_CYC)
) i_flow_out_chk (.*);

// ---- sim/pulse_sink_model.sv ----
/*
  Far-side model of output 1: an external counter that counts and measures
  pulses, and a controller that drives reset commands onto the pin.
  Assumes the bench resolves the pin from the device's out1Oe enable alone.
*/
`timescale 1ns/1ps
module pulse_sink_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic out1Out,
  input wire logic out1Oe,
  output logic ctlDrv,
  output int pulseCount,
  output int lastHigh
);
  int hiRun; // high samples of the current pulse
  logic prevQ; // pulse level one clock ago

  initial ctlDrv = 1'b0;

  // count rising edges and time each high phase
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pulseCount <= 0;
      hiRun <= 0;
      lastHigh <= 0;
      prevQ <= 1'b0;
    end else begin
      prevQ <= out1Out;
      // only a driven pin can be counted
      if (out1Oe && out1Out && !prevQ) begin
        pulseCount <= pulseCount + 1;
      end
      hiRun <= out1Out ? hiRun + 1 : 0;
      if (prevQ && !out1Out) begin
        lastHigh <= hiRun;
      end
    end
  end

  // high command of len clocks, then a quiet spell for the answer
  task automatic ctl_pulse(input int len);
    @(posedge ref_clk);
    ctlDrv <= 1'b1;
    repeat (len) @(posedge ref_clk);
    ctlDrv <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask
endmodule // pulse_sink_model

// ---- sim/testbench.sv ----
/*
  Self-checking bench: registers over AXI4-Lite, pulse train, menu and
  overflow, control input, analogue mapping and frequency output.
  Assumes shortened tick, millisecond and control-window parameters.
*/
`timescale 1ns/1ps
module testbench;
  import flow_out_pkg::*;
  localparam int UPD = 200; // shortened update tick
  localparam int MSC = 10; // shortened millisecond
  localparam int CMIN = 20, CMAX = 160; // shortened control window
  logic ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, volValid, flowOverflow;
  logic menuActive, devFault, ctlPinIn, ctlDrv, out1Out, out1Oe, freqOut;
  logic minMaxRst, partVolRst;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] volInc, measValue, anaLinUa, anaOutUa;
  int pulseCount, lastHigh, hi, lo, c0;
  int mmCount = 0, pvCount = 0, mismatches = 0, checked = 0, cycles = 0;
  // tables: reset values, clamped settings, analogue mapping
  logic [31:0] rVal [9] = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h1f4, 32'h1,
    32'h0, 32'hffff, 32'h0};
  logic [7:0] cAddr [6] = '{8'h04, 8'h04, 8'h10, 8'h10, 8'h14, 8'h14};
  logic [31:0] cIn [6] = '{32'h0, 32'h7530, 32'h14, 32'h7d0, 32'h0, 32'hc8};
  logic [31:0] cOut [6] = '{32'h1, 32'h4e20, 32'h32, 32'h3e8, 32'h1, 32'h64};
  logic [15:0] aIn [6] = '{16'h5208, 16'h3e8, 16'hf3c, 16'h5078, 16'h5014,
    16'h2710};
  logic [15:0] aExp [6] = '{16'h5208, 16'hed8, 16'hf3c, 16'h55f0, 16'h5014,
    16'he10};

  // the pin: device drives it unless in control-input mode
  assign ctlPinIn = out1Oe ? out1Out : ctlDrv;

  flow_pulse_freq_output #(.UPDATE_CYC(UPD), .MS_CYC(MSC),
    .CTL_MIN_CYC(CMIN), .CTL_MAX_CYC(CMAX)) i_flow_pulse_freq_output (
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .*);

  pulse_sink_model i_pulse_sink_model (.*);

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // reset pulse counters and hang guard
  always @(posedge ref_clk) begin
    mmCount <= mmCount + int'(minMaxRst === 1'b1);
    pvCount <= pvCount + int'(partVolRst === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // measured cycle counts may be off by a clock or two
  task automatic near(input int got, input int exp);
    chk(32'((got - exp > -3 && got - exp < 3) ? exp : got), 32'(exp));
  endtask

  // both halves offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic awDone;
    logic wDone;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    awDone = 1'b0;
    wDone = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge ref_clk);
      if (awready === 1'b1 && !awDone) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wDone) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    chk(rd, exp);
    chk(32'(rsp), 32'(RESP_OKAY));
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic add_vol(input logic [15:0] v);
    @(posedge ref_clk);
    volInc <= v;
    volValid <= 1'b1;
    @(posedge ref_clk);
    volValid <= 1'b0;
  endtask

  // one full high phase then one full low phase
  task automatic freq_half(output int h, output int l);
    h = 0;
    l = 0;
    do @(posedge ref_clk); while (freqOut !== 1'b0);
    do @(posedge ref_clk); while (freqOut !== 1'b1);
    while (freqOut === 1'b1) begin
      h++;
      @(posedge ref_clk);
    end
    while (freqOut === 1'b0) begin
      l++;
      @(posedge ref_clk);
    end
  endtask

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {volValid, flowOverflow, menuActive, devFault} = 4'h0;
    {awaddr, araddr, wdata, wstrb} = 52'hf;
    {volInc, measValue, anaLinUa} = 48'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rchk((i == 8) ? 8'h24 : 8'(4 * i), rVal[i]);
    end
    // out-of-range settings are clamped
    for (int i = 0; i < 6; i++) begin
      axi_write(cAddr[i], cIn[i]);
      rchk(cAddr[i], cOut[i]);
    end
    axi_write(8'h28, 32'h1);
    chk(32'(rsp), 32'(RESP_SLVERR));
    axi_read(8'h28);
    chk(32'(rsp), 32'(RESP_SLVERR));
    chk(rd, 32'h0);
    // lag flag at and just past the limit; low byte lane only
    axi_write(OFS_PULSE_WIDTH, 32'h14);
    wstrb <= 4'h1;
    axi_write(OFS_PULSE_VOL, 32'h3305);
    wstrb <= 4'hf;
    rchk(OFS_PULSE_VOL, 32'h5);
    axi_write(OFS_UNIT_SIZE, 32'h2);
    axi_write(OFS_RANGE_END, 32'h2bf2);
    axi_read(OFS_STATUS);
    chk(32'(rd[21]), 32'h0);
    axi_write(OFS_RANGE_END, 32'h2bf3);
    axi_read(OFS_STATUS);
    chk(32'(rd[21]), 32'h1);
    axi_write(OFS_PULSE_WIDTH, 32'h2);
    // pulses of effective volume 10: 25 gives 2, rest 5 plus 15 gives 2
    axi_write(OFS_CTRL, 32'h1);
    c0 = pulseCount;
    add_vol(16'h19);
    wt(2 * UPD);
    chk(32'(pulseCount - c0), 32'h2);
    chk(32'(lastHigh), 32'(2 * MSC));
    chk(32'(out1Oe), 32'h1);
    add_vol(16'hf);
    wt(2 * UPD);
    chk(32'(pulseCount - c0), 32'h4);
    // menu mode owes three pulses and pays them afterwards
    menuActive <= 1'b1;
    add_vol(16'h1e);
    wt(3 * UPD);
    chk(32'(pulseCount - c0), 32'h4);
    menuActive <= 1'b0;
    wt(2 * UPD);
    chk(32'(pulseCount - c0), 32'h7);
    // overflow holds the output high with no pulses
    flowOverflow <= 1'b1;
    add_vol(16'h14);
    wt(UPD);
    c0 = pulseCount;
    chk(32'(out1Out), 32'h1);
    wt(UPD);
    chk(32'(out1Out), 32'h1);
    chk(32'(pulseCount - c0), 32'h0);
    flowOverflow <= 1'b0;
    wt(2 * UPD);
    // control input: only commands inside the window act
    axi_write(OFS_CTRL, 32'h4);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, out1Oe}, 32'h0);
    i_pulse_sink_model.ctl_pulse(15);
    i_pulse_sink_model.ctl_pulse(40);
    i_pulse_sink_model.ctl_pulse(200);
    chk(32'(mmCount), 32'h1);
    axi_write(OFS_CTRL, 32'hc);
    i_pulse_sink_model.ctl_pulse(40);
    chk(32'(pvCount), 32'h1);
    chk(32'(mmCount), 32'h1);
    for (int i = 0; i < 6; i++) begin
      axi_write(OFS_CTRL, {27'h0, i != 0, 4'h0});
      devFault <= (i == 5);
      anaLinUa <= aIn[i];
      repeat (3) @(posedge ref_clk);
      chk({16'h0, anaOutUa}, {16'h0, aExp[i]});
    end
    devFault <= 1'b0;
    // full scale 1000 Hz, then overflow at twice that, then zero
    axi_write(OFS_VAL_MAX, 32'h3e8);
    measValue <= 16'h3e8;
    axi_write(OFS_CTRL, 32'h2);
    freq_half(hi, lo);
    near(hi, CLK_HZ / 2000);
    near(lo, CLK_HZ / 2000);
    measValue <= 16'h834;
    freq_half(hi, lo);
    near(hi, CLK_HZ / 4000);
    measValue <= 16'h0;
    repeat (10) @(posedge ref_clk);
    rd[0] = freqOut;
    c0 = 0;
    repeat (3000) begin
      @(posedge ref_clk);
      c0 += int'(freqOut !== rd[0]);
    end
    chk(32'(c0), 32'h0);
    end_of_test();
  end
endmodule // testbench

// ---- verilog/flow_out_pkg.sv ----
/*
  Constants for the flowmeter output stage: offsets, bit positions, reset
  values, timing figures and pulse states. Assumes one 20 MHz clock.
*/
package flow_out_pkg;
  // clock and timing figures
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned UPDATE_MS = 20;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned UPDATE_CYCLES = MS_CYCLES * UPDATE_MS;
  localparam int unsigned CTL_MIN_MS = 500;
  localparam int unsigned CTL_MAX_MS = 4000;
  localparam int unsigned CTL_MIN_CYCLES = MS_CYCLES * CTL_MIN_MS;
  localparam int unsigned CTL_MAX_CYCLES = MS_CYCLES * CTL_MAX_MS;
  localparam logic [47:0] LAG_LIMIT = 48'd22500;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PULSE_WIDTH = 8'h04;
  localparam logic [7:0] OFS_PULSE_VOL = 8'h08;
  localparam logic [7:0] OFS_UNIT_SIZE = 8'h0c;
  localparam logic [7:0] OFS_FREQ_MAX = 8'h10;
  localparam logic [7:0] OFS_FREQ_OVF = 8'h14;
  localparam logic [7:0] OFS_VAL_ZERO = 8'h18;
  localparam logic [7:0] OFS_VAL_MAX = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_RANGE_END = 8'h24;
  // control register bit positions
  localparam int unsigned CB_PULSE_EN = 0;
  localparam int unsigned CB_FREQ_EN = 1;
  localparam int unsigned CB_CTL_IN = 2;
  localparam int unsigned CB_CTL_PARTVOL = 3;
  localparam int unsigned CB_FAULT_SIG = 4;
  // limits and reset values
  localparam logic [14:0] WIDTH_MIN = 15'd1;
  localparam logic [14:0] WIDTH_MAX = 15'd20000;
  localparam logic [9:0] FMAX_MIN = 10'd50;
  localparam logic [9:0] FMAX_MAX = 10'd1000;
  localparam logic [9:0] FMAX_RST = 10'd500;
  localparam logic [6:0] OVF_MIN = 7'd1;
  localparam logic [6:0] OVF_MAX = 7'd100;
  localparam logic [15:0] UNIT_RST = 16'h0001;
  localparam logic [15:0] VAL_MAX_RST = 16'hffff;
  // analogue codes in microamps
  localparam logic [15:0] UA_LIN_LO = 16'd3800;
  localparam logic [15:0] UA_LIN_HI = 16'd20500;
  localparam logic [15:0] UA_OVER = 16'd22000;
  localparam logic [15:0] UA_FAULT = 16'd3600;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // pulse generator states, gray along idle-high-low
  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_HIGH = 2'b01,
    PS_LOW = 2'b11
  } pulse_state_t;
endpackage

// ---- verilog/flow_pulse_freq_output.sv ----
/*
  Flowmeter output stage: pulse train, frequency output, output 1 control
  input and fault-signalling analogue codes, behind an AXI4-Lite slave.
  Assumes all inputs synchronous to ref_clk.
*/
`timescale 1ns/1ps
module flow_pulse_freq_output #(
  parameter int unsigned UPDATE_CYC = flow_out_pkg::UPDATE_CYCLES,
  parameter int unsigned MS_CYC = flow_out_pkg::MS_CYCLES,
  parameter int unsigned CTL_MIN_CYC = flow_out_pkg::CTL_MIN_CYCLES,
  parameter int unsigned CTL_MAX_CYC = flow_out_pkg::CTL_MAX_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] volInc,
  input wire logic volValid,
  input wire logic flowOverflow,
  input wire logic menuActive,
  input wire logic [15:0] measValue,
  input wire logic [15:0] anaLinUa,
  input wire logic devFault,
  input wire logic ctlPinIn,
  output logic out1Out,
  output logic out1Oe,
  output logic freqOut,
  output logic [15:0] anaOutUa,
  output logic minMaxRst,
  output logic partVolRst
);
  import flow_out_pkg::*;

  // whole block state, registered in one place
  typedef struct packed {
    logic awReady;
    logic wReady;
    logic arReady;
    logic awHave;            // write address held
    logic [7:0] awAddr;
    logic wHave;             // write data held
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [7:0] ctrl;
    logic [14:0] pulseWidth; // ms
    logic [15:0] pulseVol;   // in user units
    logic [15:0] unitSize;   // volume lsb per user unit
    logic [9:0] freqMax;     // Hz
    logic [6:0] ovfPct;
    logic [15:0] valZero;
    logic [15:0] valMax;
    logic [15:0] rangeEnd;   // measurement_range_end
    logic [31:0] tickCnt;
    logic [31:0] periodVol;  // volume of the running period
    logic [32:0] volAcc;     // volume not yet turned into pulses
    logic [15:0] backlog;    // pulses owed
    pulse_state_t pState;
    logic [31:0] msCnt;
    logic [14:0] widthCnt;
    logic pulseOut;
    logic [47:0] freqAcc;
    logic freqOut;
    logic freqOvf;
    logic ctlPrev;
    logic [31:0] hiCnt;
    logic minMaxRst;
    logic partVolRst;
    logic [15:0] anaOut;
  } state_t;

  state_t s_q, s_d;

  // merge a write into a register honouring byte strobes
  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // address decode shared by read and write paths
  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_RANGE_END);
  endfunction

  // register image as software reads it, fields in the low bits
  function automatic logic [31:0] regRead(input state_t st,
      input logic [7:0] a, input logic [31:0] stat);
    unique case (a)
      OFS_CTRL: return {24'h0, st.ctrl};
      OFS_PULSE_WIDTH: return {17'h0, st.pulseWidth};
      OFS_PULSE_VOL: return {16'h0, st.pulseVol};
      OFS_UNIT_SIZE: return {16'h0, st.unitSize};
      OFS_FREQ_MAX: return {22'h0, st.freqMax};
      OFS_FREQ_OVF: return {25'h0, st.ovfPct};
      OFS_VAL_ZERO: return {16'h0, st.valZero};
      OFS_VAL_MAX: return {16'h0, st.valMax};
      OFS_STATUS: return stat;
      OFS_RANGE_END: return {16'h0, st.rangeEnd};
      default: return 32'h0;
    endcase
  endfunction

  // clamp a written value into its legal span
  function automatic logic [31:0] clampTo(input logic [31:0] v,
      input logic [31:0] lo, input logic [31:0] hi);
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  // combinational helpers, assigned at the top of the process
  logic [31:0] wVal;
  logic [31:0] effVol;
  logic [15:0] delta;
  logic [15:0] span;
  logic [47:0] fInc;
  logic [47:0] fLim;
  logic [47:0] fSum;
  logic lagRisk;
  logic emitOk;
  logic [31:0] statusWord;

  // next-state logic for bus, pulse, frequency, control input, analogue
  always_comb begin
    s_d = s_q;
    wVal = 32'h0;
    effVol = s_q.pulseVol * s_q.unitSize;
    delta = (measValue > s_q.valZero) ? measValue - s_q.valZero : 16'h0;
    span = (s_q.valMax > s_q.valZero) ? s_q.valMax - s_q.valZero : 16'h0;
    fInc = 48'h0;
    fLim = 48'h0;
    fSum = 48'h0;
    // owed pulses lag when range end times width over volume passes limit
    lagRisk = (48'(s_q.rangeEnd) * 48'(s_q.pulseWidth))
              > (LAG_LIMIT * 48'(effVol));
    emitOk = s_q.ctrl[CB_PULSE_EN] && !menuActive && !flowOverflow;
    statusWord = {8'h0, 1'b0, s_q.freqOvf, lagRisk, s_q.pulseOut,
                  2'(s_q.pState), 2'b00, s_q.backlog};

    // write address and data are taken in either order
    if (s_axi_awvalid && s_q.awReady) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wReady) begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    // perform the write once both halves are held
    if (s_q.awHave && s_q.wHave && !s_q.bValid) begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = isMapped(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      wVal = mergeStrb(regRead(s_q, s_q.awAddr, statusWord), s_q.wData,
                       s_q.wStrb);
      unique case (s_q.awAddr)
        OFS_CTRL: begin
          s_d.ctrl = {3'b000, wVal[4:0]};
        end
        OFS_PULSE_WIDTH: begin
          // width clamped into the legal 1 ms .. 20 s span
          s_d.pulseWidth = 15'(clampTo(wVal, 32'(WIDTH_MIN),
                                       32'(WIDTH_MAX)));
        end
        OFS_PULSE_VOL: begin
          s_d.pulseVol = wVal[15:0];
        end
        OFS_UNIT_SIZE: begin
          s_d.unitSize = wVal[15:0];
        end
        OFS_FREQ_MAX: begin
          s_d.freqMax = 10'(clampTo(wVal, 32'(FMAX_MIN),
                                    32'(FMAX_MAX)));
        end
        OFS_FREQ_OVF: begin
          s_d.ovfPct = 7'(clampTo(wVal, 32'(OVF_MIN),
                                  32'(OVF_MAX)));
        end
        OFS_VAL_ZERO: begin
          s_d.valZero = wVal[15:0];
        end
        OFS_VAL_MAX: begin
          s_d.valMax = wVal[15:0];
        end
        OFS_RANGE_END: begin
          s_d.rangeEnd = wVal[15:0];
        end
        // status is read only; unmapped already answered with an error
        default: begin
        end
      endcase
    end

    // read path, one cycle after the address is taken
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arReady) begin
      s_d.rValid = 1'b1;
      s_d.rResp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_d.rData = regRead(s_q, s_axi_araddr, statusWord);
    end
    // readies come from flops so they fall as soon as a slot is taken
    s_d.awReady = !s_d.awHave && !s_d.bValid;
    s_d.wReady = !s_d.wHave && !s_d.bValid;
    s_d.arReady = !s_d.rValid;

    // 20 ms update tick; volume of the closed period joins the remainder
    if (s_q.tickCnt >= UPDATE_CYC - 1) begin
      s_d.tickCnt = 32'h0;
      s_d.volAcc = s_q.volAcc + 33'(s_q.periodVol);
      s_d.periodVol = volValid ? 32'(volInc) : 32'h0;
    end else begin
      s_d.tickCnt = s_q.tickCnt + 32'h1;
      // one pulse volume per cycle turns into one owed pulse
      if (effVol != 32'h0 && s_q.volAcc >= 33'(effVol)
          && s_q.backlog != 16'hffff) begin
        s_d.volAcc = s_q.volAcc - 33'(effVol);
        s_d.backlog = s_q.backlog + 16'h1;
      end
      if (volValid) begin
        s_d.periodVol = s_q.periodVol + 32'(volInc);
      end
    end
    if (!s_q.ctrl[CB_PULSE_EN]) begin
      // a disabled output forgets owed volume
      s_d.volAcc = 33'h0;
      s_d.backlog = 16'h0;
      s_d.periodVol = 32'h0;
    end

    // pulse generator: high for width, low for width, then next
    s_d.msCnt = s_q.msCnt + 32'h1;
    if (s_q.msCnt >= MS_CYC - 1) begin
      s_d.msCnt = 32'h0;
      s_d.widthCnt = s_q.widthCnt + 15'h1;
    end
    unique case (s_q.pState)
      PS_IDLE: begin
        s_d.msCnt = 32'h0;
        s_d.widthCnt = 15'h0;
        // menu mode or overflow holds the backlog unspent
        if (emitOk && s_q.backlog != 16'h0) begin
          s_d.pState = PS_HIGH;
        end
      end
      PS_HIGH: begin
        if (s_q.msCnt >= MS_CYC - 1
            && s_q.widthCnt == s_q.pulseWidth - 15'h1) begin
          s_d.pState = PS_LOW;
          s_d.msCnt = 32'h0;
          s_d.widthCnt = 15'h0;
          // a disable in this cycle has already emptied the backlog
          if (s_d.backlog != 16'h0) begin
            s_d.backlog = s_d.backlog - 16'h1;
          end
        end
      end
      PS_LOW: begin
        // gap equals width so back to back pulses stay countable
        if (s_q.msCnt >= MS_CYC - 1
            && s_q.widthCnt == s_q.pulseWidth - 15'h1) begin
          s_d.pState = PS_IDLE;
        end
      end
    endcase
    if (flowOverflow || !s_q.ctrl[CB_PULSE_EN]) begin
      s_d.pState = PS_IDLE;
    end
    // overflow forces a steady high level
    s_d.pulseOut = flowOverflow ? s_q.ctrl[CB_PULSE_EN]
                                : (s_d.pState == PS_HIGH);

    // frequency output: toggle accumulator, two toggles per period
    s_d.freqOvf = (24'(delta) * 24'd100)
                  > (24'(span) * (24'd100 + 24'(s_q.ovfPct)));
    if (s_d.freqOvf) begin
      fInc = 48'(s_q.freqMax) * (48'd200 + 48'(2 * s_q.ovfPct));
      fLim = 48'(CLK_HZ) * 48'd100;
    end else begin
      fInc = 48'(s_q.freqMax) * 48'(delta) * 48'd2;
      fLim = 48'(CLK_HZ) * 48'(span);
    end
    fSum = s_q.freqAcc + fInc;
    if (!s_q.ctrl[CB_FREQ_EN] || fLim == 48'h0) begin
      s_d.freqAcc = 48'h0;
      s_d.freqOut = 1'b0;
    end else if (fSum >= fLim) begin
      // equal high and low halves within one clock
      s_d.freqAcc = (fSum - fLim >= fLim) ? 48'h0 : fSum - fLim;
      s_d.freqOut = !s_q.freqOut;
    end else begin
      s_d.freqAcc = fSum;
    end

    // control input on output 1: measure each high pulse
    s_d.minMaxRst = 1'b0;
    s_d.partVolRst = 1'b0;
    s_d.ctlPrev = ctlPinIn && s_q.ctrl[CB_CTL_IN];
    if (s_d.ctlPrev) begin
      if (s_q.hiCnt != CTL_MAX_CYC) begin
        s_d.hiCnt = s_q.hiCnt + 32'h1; // saturates at the upper bound
      end
    end else begin
      s_d.hiCnt = 32'h0;
      // act on falling edge only for strictly in-window pulses
      if (s_q.ctlPrev && s_q.hiCnt > CTL_MIN_CYC
          && s_q.hiCnt < CTL_MAX_CYC) begin
        s_d.minMaxRst = !s_q.ctrl[CB_CTL_PARTVOL];
        s_d.partVolRst = s_q.ctrl[CB_CTL_PARTVOL];
      end
    end

    // analogue code mapping with fault signalling
    if (!s_q.ctrl[CB_FAULT_SIG]) begin
      s_d.anaOut = anaLinUa;
    end else if (devFault) begin
      s_d.anaOut = UA_FAULT;
    end else if (anaLinUa > UA_LIN_HI) begin
      s_d.anaOut = UA_OVER;
    end else if (anaLinUa < UA_LIN_LO) begin
      s_d.anaOut = UA_LIN_LO;
    end else begin
      s_d.anaOut = anaLinUa;
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.pulseWidth <= WIDTH_MIN;
      s_q.unitSize <= UNIT_RST;
      s_q.freqMax <= FMAX_RST;
      s_q.ovfPct <= OVF_MIN;
      s_q.valMax <= VAL_MAX_RST;
      s_q.pState <= PS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register, out1Oe decoded from two of its fields
  assign s_axi_awready = s_q.awReady;
  assign s_axi_wready = s_q.wReady;
  assign s_axi_arready = s_q.arReady;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign out1Out = s_q.pulseOut;
  assign out1Oe = !s_q.ctlPrev && !s_q.ctrl[CB_CTL_IN];
  assign freqOut = s_q.freqOut;
  assign anaOutUa = s_q.anaOut;
  assign minMaxRst = s_q.minMaxRst;
  assign partVolRst = s_q.partVolRst;
endmodule // flow_pulse_freq_output
